/* hdl/orient_pkg.sv */
// Orientation detection package: register map, fields, reset values, time steps
package orient_pkg;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_CONFIG = 8'h11;
    localparam logic [7:0] ADDR_DEBOUNCE = 8'h12;
    localparam logic [7:0] ADDR_ANGLE_LIMITS = 8'h13;
    localparam logic [7:0] ADDR_TRIP_THRESHOLD = 8'h14;

    localparam int STATUS_CHANGE_BIT = 7;
    localparam int STATUS_LOCKOUT_BIT = 6;
    localparam int STATUS_CODE_LSB = 1;
    localparam int STATUS_FACE_BIT = 0;
    localparam int CONFIG_MODE_BIT = 7;
    localparam int CONFIG_ENABLE_BIT = 6;

    localparam logic CONFIG_MODE_RESET = 1'h1;
    localparam logic CONFIG_ENABLE_RESET = 1'h0;
    localparam logic [7:0] DEBOUNCE_RESET = 8'h00;

    // Fixed angle codes
    localparam logic [1:0] FACE_TRIP_CODE = 2'h1;
    localparam logic [2:0] TILT_LOCK_CODE = 3'h4;
    localparam logic [4:0] ORIENT_TRIP_CODE = 5'h10;
    localparam logic [2:0] HYSTERESIS_CODE = 3'h4;
    localparam logic [7:0] ANGLE_LIMITS_VALUE = {FACE_TRIP_CODE, 3'h0, TILT_LOCK_CODE};
    localparam logic [7:0] TRIP_THRESHOLD_VALUE = {ORIENT_TRIP_CODE, HYSTERESIS_CODE};

    // Orientation codes
    localparam logic [1:0] CODE_PORTRAIT_UP = 2'h0;
    localparam logic [1:0] CODE_PORTRAIT_DOWN = 2'h1;
    localparam logic [1:0] CODE_LANDSCAPE_RIGHT = 2'h2;
    localparam logic [1:0] CODE_LANDSCAPE_LEFT = 2'h3;

    // Oversampling modes
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_LOW_NOISE_LOW_POWER = 2'b01,
        MODE_HIGH_RESOLUTION = 2'b10,
        MODE_LOW_POWER = 2'b11
    } oversample_mode_type;

    // Output data rate codes: 800,400,200,100,50,12.5,6.25,1.56 Hz
    localparam logic [2:0] RATE_800 = 3'h0;
    localparam logic [2:0] RATE_400 = 3'h1;
    localparam logic [2:0] RATE_200 = 3'h2;
    localparam logic [2:0] RATE_100 = 3'h3;
    localparam logic [2:0] RATE_50 = 3'h4;
    localparam logic [2:0] RATE_12P5 = 3'h5;

    // Time steps in units of 1.25 ms
    localparam logic [7:0] STEP_1P25 = 8'h01;
    localparam logic [7:0] STEP_2P5 = 8'h02;
    localparam logic [7:0] STEP_5 = 8'h04;
    localparam logic [7:0] STEP_10 = 8'h08;
    localparam logic [7:0] STEP_20 = 8'h10;
    localparam logic [7:0] STEP_80 = 8'h40;
    localparam logic [7:0] STEP_160 = 8'h80;

    // Per-sample orientation result from the angle computation
    typedef struct packed {
        logic tilt_lockout;
        logic [1:0] orient_code;
        logic face_side;
        logic over_limit;
    } orient_sample_type;

    typedef struct packed {
        logic orient_change_flag;
        logic tilt_lockout;
        logic [1:0] orient_code;
        logic face_side;
    } orient_status_type;
endpackage : orient_pkg

/* hdl/orient_debounce.sv */
// Debounce counter for orientation candidates, counted in 1.25 ms ticks
`timescale 1ns/1ns
`default_nettype none
module orient_debounce #(
    parameter int COUNT_WIDTH = 16
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_clear,
    input wire logic i_tick,
    input wire logic i_differs,
    input wire logic i_decrement_mode,
    input wire logic [7:0] i_step,
    input wire logic [7:0] i_debounce_value,
    output logic o_accept
);
    logic [COUNT_WIDTH-1:0] count_reg;
    logic [COUNT_WIDTH-1:0] count_next;
    logic [COUNT_WIDTH-1:0] target;

    // Target in 1.25 ms units; wide enough for 255 steps of 160 ms
    assign target = COUNT_WIDTH'(i_debounce_value) * COUNT_WIDTH'(i_step);
    assign o_accept = i_tick && i_differs && (count_next >= target);

    always_comb begin
        count_next = count_reg;
        if (i_clear) begin
            count_next = '0;
        end else if (i_tick) begin
            if (i_differs) begin
                if (count_reg < target) begin
                    count_next = count_reg + COUNT_WIDTH'(1);
                end
            end else if (i_decrement_mode) begin
                if (count_reg != '0) begin
                    count_next = count_reg - COUNT_WIDTH'(1);
                end
            end else begin
                count_next = '0;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            count_reg <= '0;
        end else if (i_ce) begin
            count_reg <= o_accept ? '0 : count_next;
        end
    end
endmodule : orient_debounce
`default_nettype wire

/* hdl/orientation_detect_regs.sv */
// Orientation detection status, configuration and fixed angle registers
`timescale 1ns/1ns
`default_nettype none
module orientation_detect_regs #(
    parameter int COUNT_WIDTH = 16
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_write,
    input wire logic i_reg_read,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    input wire logic i_active,
    input wire logic i_sleep,
    input wire logic [2:0] i_output_sample_rate,
    input wire logic [1:0] i_oversample_mode,
    input wire logic i_sample_valid,
    input wire orient_pkg::orient_sample_type i_sample,
    input wire logic i_tick_1p25ms,
    output logic o_orient_irq
);
    orient_pkg::orient_status_type status_reg;
    orient_pkg::orient_status_type status_next;
    logic debounce_mode_sel_reg;
    logic debounce_mode_sel_next;
    logic orient_detect_enable_reg;
    logic orient_detect_enable_next;
    logic [7:0] debounce_value_reg;
    logic [7:0] debounce_value_next;
    logic first_pending_reg;
    logic first_pending_next;
    logic active_prev_reg;
    logic sleep_prev_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [7:0] step;
    logic step_tick;
    logic running;
    logic differs;
    logic accept;
    logic clear_counter;
    logic status_read;

    // Step in 1.25 ms units for a given rate and oversampling mode
    function automatic logic [7:0] step_for(input logic [2:0] rate, input logic [1:0] mode);
        logic [7:0] s;
        s = orient_pkg::STEP_20;
        case (rate)
            orient_pkg::RATE_800: s = orient_pkg::STEP_1P25;
            orient_pkg::RATE_400: s = orient_pkg::STEP_2P5;
            orient_pkg::RATE_200: s = orient_pkg::STEP_5;
            orient_pkg::RATE_100: s = orient_pkg::STEP_10;
            orient_pkg::RATE_50: s = orient_pkg::STEP_20;
            default: begin
                if (mode == orient_pkg::MODE_LOW_NOISE_LOW_POWER) begin
                    s = orient_pkg::STEP_80;
                end else if (mode == orient_pkg::MODE_LOW_POWER) begin
                    s = (rate == orient_pkg::RATE_12P5) ? orient_pkg::STEP_80
                                                        : orient_pkg::STEP_160;
                end else begin
                    s = orient_pkg::STEP_20;
                end
            end
        endcase
        // High resolution never goes slower than 2.5 ms
        if (mode == orient_pkg::MODE_HIGH_RESOLUTION && rate != orient_pkg::RATE_800) begin
            s = orient_pkg::STEP_2P5;
        end
        return s;
    endfunction : step_for

    // ==============================================================
    // Control decode
    assign status_read = i_reg_read && (i_reg_addr == orient_pkg::ADDR_STATUS);
    assign running = orient_detect_enable_reg && i_active;
    assign step = step_for(i_output_sample_rate, i_oversample_mode);
    assign differs = (i_sample.tilt_lockout != status_reg.tilt_lockout)
                  || (i_sample.orient_code != status_reg.orient_code)
                  || (i_sample.face_side != status_reg.face_side);
    // Counter cleared on sleep edges and whenever detection is idle
    assign clear_counter = !running || (i_sleep != sleep_prev_reg);
    // Every 1.25 ms tick without over_limit counts; the step weight lives in the debounce target
    assign step_tick = running && i_tick_1p25ms && !i_sample.over_limit;

    orient_debounce #(
        .COUNT_WIDTH(COUNT_WIDTH)
    ) u_debounce (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_clear(clear_counter),
        .i_tick(step_tick),
        .i_differs(differs),
        .i_decrement_mode(!debounce_mode_sel_reg),
        .i_step(step),
        .i_debounce_value(debounce_value_reg),
        .o_accept(accept)
    );

    // ==============================================================
    // Status and configuration
    always_comb begin
        status_next = status_reg;
        first_pending_next = first_pending_reg;
        debounce_mode_sel_next = debounce_mode_sel_reg;
        orient_detect_enable_next = orient_detect_enable_reg;
        debounce_value_next = debounce_value_reg;
        if (i_active && !active_prev_reg) begin
            first_pending_next = 1'b1;
        end
        if (status_read) begin
            status_next.orient_change_flag = 1'b0;
        end
        if (running && i_sample_valid && !i_sample.over_limit && first_pending_reg) begin
            // First result after activation is taken at once
            status_next.tilt_lockout = i_sample.tilt_lockout;
            status_next.orient_code = i_sample.orient_code;
            status_next.face_side = i_sample.face_side;
            status_next.orient_change_flag = 1'b1;
            first_pending_next = 1'b0;
        end else if (accept) begin
            // Fields move even with the flag still up; set beats read-clear
            status_next.tilt_lockout = i_sample.tilt_lockout;
            status_next.orient_code = i_sample.orient_code;
            status_next.face_side = i_sample.face_side;
            status_next.orient_change_flag = 1'b1;
        end
        if (i_reg_write) begin
            if (i_reg_addr == orient_pkg::ADDR_CONFIG) begin
                debounce_mode_sel_next = i_reg_wdata[orient_pkg::CONFIG_MODE_BIT];
                orient_detect_enable_next = i_reg_wdata[orient_pkg::CONFIG_ENABLE_BIT];
            end
            if (i_reg_addr == orient_pkg::ADDR_DEBOUNCE) begin
                debounce_value_next = i_reg_wdata;
            end
        end
    end

    // ==============================================================
    // Read data
    always_comb begin
        rdata_next = rdata_reg;
        if (i_reg_read) begin
            case (i_reg_addr)
                orient_pkg::ADDR_STATUS: rdata_next = {status_reg.orient_change_flag,
                    status_reg.tilt_lockout, 3'h0, status_reg.orient_code, status_reg.face_side};
                orient_pkg::ADDR_CONFIG: rdata_next = {debounce_mode_sel_reg,
                    orient_detect_enable_reg, 6'h00};
                orient_pkg::ADDR_DEBOUNCE: rdata_next = debounce_value_reg;
                orient_pkg::ADDR_ANGLE_LIMITS: rdata_next = orient_pkg::ANGLE_LIMITS_VALUE;
                orient_pkg::ADDR_TRIP_THRESHOLD: rdata_next = orient_pkg::TRIP_THRESHOLD_VALUE;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    assign o_reg_rdata = rdata_reg;
    assign o_orient_irq = status_reg.orient_change_flag;

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            status_reg <= '0;
            first_pending_reg <= 1'b0;
            debounce_mode_sel_reg <= orient_pkg::CONFIG_MODE_RESET;
            orient_detect_enable_reg <= orient_pkg::CONFIG_ENABLE_RESET;
            debounce_value_reg <= orient_pkg::DEBOUNCE_RESET;
            active_prev_reg <= 1'b0;
            sleep_prev_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else if (i_ce) begin
            status_reg <= status_next;
            first_pending_reg <= first_pending_next;
            debounce_mode_sel_reg <= debounce_mode_sel_next;
            orient_detect_enable_reg <= orient_detect_enable_next;
            debounce_value_reg <= debounce_value_next;
            active_prev_reg <= i_active;
            sleep_prev_reg <= i_sleep;
            rdata_reg <= rdata_next;
        end
    end
endmodule : orientation_detect_regs
`default_nettype wire

/* verif/orient_regs_monitor.sv */
// Port checker for the orientation register block
`timescale 1ns/1ns
`default_nettype none
module orient_regs_monitor (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_read,
    input wire logic [7:0] o_reg_rdata,
    input wire logic i_active,
    input wire logic i_sample_valid,
    input wire logic i_tick_1p25ms,
    input wire logic o_orient_irq
);
    // ==========================================
    // Sequences
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    sequence rd_s(logic [7:0] a);
        i_ce && i_reg_read && i_reg_addr == a;
    endsequence
    // No new result can land while these hold
    sequence quiet_s;
        !i_sample_valid && !i_tick_1p25ms;
    endsequence
    // ==========================================
    // Assertions
    AST_RST_ZERO: assert property ($rose(i_nrst) |-> o_reg_rdata == 8'h00 && !o_orient_irq)
        else $error("outputs not clear after reset");
    AST_FLAG_IRQ: assert property (rd_s(8'h10) |=> o_reg_rdata[7] == $past(o_orient_irq))
        else $error("status flag differs from irq");
    AST_IRQ_CLEAR: assert property (quiet_s ##1 quiet_s ##1 (rd_s(8'h10) and quiet_s)
        |=> !o_orient_irq) else $error("irq kept after status read");
    AST_IRQ_HOLD: assert property (o_orient_irq && !(i_ce && i_reg_read) |=> o_orient_irq)
        else $error("irq dropped without a read");
    AST_ANGLES: assert property (rd_s(8'h13) |=> o_reg_rdata == 8'h44)
        else $error("angle limits wrong");
    AST_TRIP: assert property (rd_s(8'h14) |=> o_reg_rdata == 8'h84)
        else $error("trip threshold wrong");
    AST_RSVD_ZERO: assert property (rd_s(8'h10) |=> o_reg_rdata[5:3] == 3'h0)
        else $error("status spare bits set");
    AST_STANDBY: assert property (!i_active && !o_orient_irq |=> !o_orient_irq)
        else $error("change flagged in standby");
    AST_UNMAPPED: assert property (i_ce && i_reg_read && (i_reg_addr < 8'h10 || i_reg_addr > 8'h14)
        |=> o_reg_rdata == 8'h00) else $error("unmapped read not zero");
endmodule : orient_regs_monitor
`default_nettype wire

/* verif/orient_host_model.sv */
// Host model issuing single register accesses
`timescale 1ns/1ns
`default_nettype none
module orient_host_model (
    input wire logic i_core_clk,
    input wire logic [7:0] i_reg_rdata,
    output logic [7:0] o_reg_addr,
    output logic o_reg_write,
    output logic o_reg_read,
    output logic [7:0] o_reg_wdata
);
    // ==========================================
    // Access
    initial begin
        o_reg_addr = 8'h00;
        o_reg_write = 1'b0;
        o_reg_read = 1'b0;
        o_reg_wdata = 8'h00;
    end
    task automatic access(input logic w, input logic [7:0] a, d, output logic [7:0] q);
        @(negedge i_core_clk);
        o_reg_addr = a;
        o_reg_wdata = d;
        o_reg_write = w;
        o_reg_read = !w;
        @(negedge i_core_clk);
        q = i_reg_rdata;
        // Idle bus shows inverted values so stale ones cannot pass
        o_reg_addr = ~a;
        o_reg_wdata = ~d;
        o_reg_write = 1'b0;
        o_reg_read = 1'b0;
    endtask : access
endmodule : orient_host_model
`default_nettype wire

/* verif/tb_orientation_detect_regs.sv */
// Self-checking bench for the orientation register block
`timescale 1ns/1ns
`default_nettype none
module tb_orientation_detect_regs;
    // ==========================================
    // Signals
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic active = 1'b0;
    logic tick = 1'b0;
    logic valid = 1'b0;
    logic [2:0] rate = 3'h0;
    logic [1:0] mode = 2'h0;
    orient_pkg::orient_sample_type smp = '0;
    orient_pkg::orient_sample_type last;
    orient_pkg::orient_sample_type nxt;
    logic sleep = 1'b0;
    logic [7:0] addr, wdata, rdata, q, r8;
    logic wr, rd, irq;
    logic [31:0] seed = 32'd65477;
    logic [7:0] ra [6] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h20};
    logic [7:0] re [6] = '{8'h00, 8'h80, 8'h00, 8'h44, 8'h84, 8'h00};
    int err_count = 0;
    int checked = 0;
    int cycles = 0;
    int n;
    always #20 clk = ~clk;
    orientation_detect_regs #(.COUNT_WIDTH(16)) orientation_detect_regs_i (.i_core_clk(clk),
        .i_nrst(nrst), .i_ce(1'b1), .i_reg_addr(addr), .i_reg_write(wr), .i_reg_read(rd),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_active(active), .i_sleep(sleep),
        .i_output_sample_rate(rate), .i_oversample_mode(mode), .i_sample_valid(valid),
        .i_sample(smp), .i_tick_1p25ms(tick), .o_orient_irq(irq));
    orient_host_model orient_host_model_i (.i_core_clk(clk), .i_reg_rdata(rdata),
        .o_reg_addr(addr), .o_reg_write(wr), .o_reg_read(rd), .o_reg_wdata(wdata));
    // ==========================================
    // Helpers
    function automatic logic [7:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : xs
    // Ticks of 1.25 ms per debounce step
    function automatic int step_ticks(input logic [2:0] r, input logic [1:0] m);
        if (r == 3'h0) return 1;
        if (r == 3'h1 || m == 2'h2) return 2;
        if (r < 3'h5) return 4 << (r - 3'h2);
        if (m == 2'h0) return 16;
        if (m == 2'h3 && r != 3'h5) return 128;
        return 64;
    endfunction : step_ticks
    function automatic logic [7:0] exp_st(input logic f, input orient_pkg::orient_sample_type s);
        return {f, s.tilt_lockout, 3'h0, s.orient_code, s.face_side};
    endfunction : exp_st
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic acc(input logic w, input logic [7:0] a, d);
        orient_host_model_i.access(w, a, d, q);
    endtask : acc
    task automatic rd_st(input logic [7:0] exp);
        acc(1'b0, 8'h10, 8'h00);
        check("status", q, exp);
        check("irq after read", {7'h0, irq}, 8'h00);
    endtask : rd_st
    task automatic ticks(input int k);
        repeat (k) begin
            @(negedge clk);
            tick = 1'b1;
            valid = 1'b1;
            @(negedge clk);
            tick = 1'b0;
            valid = 1'b0;
            repeat (2) @(negedge clk);
        end
    endtask : ticks
    task automatic new_smp();
        r8 = xs();
        // Face always flips so each new sample is a real change
        smp = {r8[2:0], ~smp.face_side, 1'b0};
    endtask : new_smp
    task automatic close_out();
        $display("counts: %0d checked, %0d failed", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out
    // ==========================================
    // Sequence
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            err_count++;
            close_out();
        end
    end
    initial begin
        repeat (16) @(negedge clk);
        nrst = 1'b1;
        acc(1'b1, 8'h13, 8'hff);
        for (int i = 0; i < 6; i++) begin
            acc(1'b0, ra[i], 8'h00);
            check("reset read", q, re[i]);
        end
        acc(1'b1, 8'h11, 8'h40);
        acc(1'b0, 8'h11, 8'h00);
        check("config", q, 8'h40);
        $display("test registers done");
        acc(1'b1, 8'h11, 8'hc0);
        active = 1'b1;
        new_smp();
        ticks(1);
        check("irq", {7'h0, irq}, 8'h01);
        rd_st(exp_st(1'b1, smp));
        for (int k = 0; k < 4; k++) begin
            new_smp();
            smp.orient_code = k[1:0];
            ticks(2);
            rd_st(exp_st(1'b1, smp));
        end
        new_smp();
        ticks(2);
        new_smp();
        ticks(2);
        rd_st(exp_st(1'b1, smp));
        last = smp;
        new_smp();
        smp.over_limit = 1'b1;
        ticks(8);
        rd_st(exp_st(1'b0, last));
        acc(1'b1, 8'h11, 8'h80);
        new_smp();
        ticks(8);
        rd_st(exp_st(1'b0, last));
        acc(1'b1, 8'h11, 8'hc0);
        active = 1'b0;
        new_smp();
        ticks(8);
        rd_st(exp_st(1'b0, last));
        active = 1'b1;
        ticks(1);
        rd_st(exp_st(1'b1, smp));
        $display("test status done");
        acc(1'b1, 8'h12, 8'h02);
        for (int i = 0; i < 6; i++) begin
            r8 = xs();
            rate = (i == 0) ? 3'h7 : r8[2:0];
            mode = (i == 0) ? 2'h3 : r8[4:3];
            n = step_ticks(rate, mode);
            new_smp();
            ticks(n);
            check("held early", {7'h0, irq}, 8'h00);
            ticks(3 * n);
            rd_st(exp_st(1'b1, smp));
        end
        $display("test debounce done");
        // Decrement mode keeps progress across a lapse
        acc(1'b1, 8'h12, 8'h04);
        acc(1'b1, 8'h11, 8'h40);
        rate = 3'h0;
        last = smp;
        new_smp();
        nxt = smp;
        ticks(3);
        smp = last;
        ticks(1);
        smp = nxt;
        ticks(1);
        check("decrement early", {7'h0, irq}, 8'h00);
        ticks(1);
        rd_st(exp_st(1'b1, nxt));
        // A sleep edge wipes partial progress
        new_smp();
        nxt = smp;
        ticks(3);
        @(negedge clk);
        sleep = 1'b1;
        @(negedge clk);
        ticks(1);
        check("sleep clear", {7'h0, irq}, 8'h00);
        ticks(3);
        rd_st(exp_st(1'b1, nxt));
        $display("test mode and sleep done");
        close_out();
    end
endmodule : tb_orientation_detect_regs
bind orientation_detect_regs orient_regs_monitor orient_regs_monitor_i (.i_core_clk, .i_nrst,
    .i_ce, .i_reg_addr, .i_reg_read, .o_reg_rdata, .i_active, .i_sample_valid, .i_tick_1p25ms,
    .o_orient_irq);
`default_nettype wire
